// ===== src/dxsmr_params.svh
// constants for the extender sublayer management register bank
// Behaviour
// - every register address in this device's space gets an answer
// - writes to undefined or read-only addresses change no state
// - reserved bits read zero and writes to them do nothing
// - latching-low bit stays low until read, then shows present condition
// - latching-high bit stays high until read, then shows present condition
// - reset bit returns all registers to defaults, bit 15 reads one
// - reset bit reads one while reset runs, clears when done
// - software reset finishes within 0.5 s
// - during reset, reads of reset bit and present field still answered
// - loopback active exactly while loopback bit is one
// - in loopback, transmit data is returned on receive path
// - low-power state still services management accesses
// - invalid speed selection writes are discarded
// - writes to status 1, status 2 and lane status have no effect
// - receive link status is latching low
// - identifier fields built from OUI, model and revision
// - transmit fault is latching high
// - receive fault is latching high
// - without pattern testing, enable bit writes dropped, reads zero
// - pattern select 10 mixed, 01 low, 00 high frequency
`ifndef DXSMR_PARAMS_SVH
`define DXSMR_PARAMS_SVH

// ****************************************
// register addresses
// ****************************************
`define DXSMR_A_CTRL1   16'h0000
`define DXSMR_A_STAT1   16'h0001
`define DXSMR_A_ID1     16'h0002
`define DXSMR_A_ID2     16'h0003
`define DXSMR_A_SPEED   16'h0004
`define DXSMR_A_DEVS1   16'h0005
`define DXSMR_A_DEVS2   16'h0006
`define DXSMR_A_STAT2   16'h0008
`define DXSMR_A_PKG1    16'h000E
`define DXSMR_A_PKG2    16'h000F
`define DXSMR_A_LANE    16'h0018
`define DXSMR_A_TEST    16'h0019

// ****************************************
// control field positions and values
// ****************************************
`define DXSMR_B_RESET   15
`define DXSMR_B_LOOP    14
`define DXSMR_B_SPD_HI  13
`define DXSMR_B_LOWPWR  11
`define DXSMR_B_SPD_LO  6
`define DXSMR_SPD_FIELD 4'h0
`define DXSMR_CTRL_RST  16'h2040
`define DXSMR_PRESENT   2'h2
`define DXSMR_TEST_RST  3'h0

// ****************************************
// timing
// ****************************************
`define DXSMR_RESET_MAX_NS 500000000
`define DXSMR_CLK_NS       40
`define DXSMR_RESET_CYC    (`DXSMR_RESET_MAX_NS / `DXSMR_CLK_NS)

`endif

// ===== src/dxsmr_pkg.sv
// types for the extender sublayer management register bank
`default_nettype none
package dxsmr_pkg;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dxsmr_mgmt_req_t;

    typedef struct packed {
        logic        ack;
        logic [15:0] rdata;
    } dxsmr_mgmt_rsp_t;

    typedef struct packed {
        logic       en;
        logic [1:0] sel;
    } dxsmr_test_t;

    typedef enum logic [1:0] {
        DXSMR_PAT_HIGH,
        DXSMR_PAT_LOW,
        DXSMR_PAT_MIXED,
        DXSMR_PAT_NONE
    } dxsmr_pattern_t;

    typedef enum { DXSMR_RUN, DXSMR_RESETTING } dxsmr_state_t;

endpackage
`default_nettype wire

// ===== src/dxsmr_regs.sv
// management register bank of the dte side extender sublayer
`timescale 1ns/100ps
`default_nettype none
`include "dxsmr_params.svh"

module dxsmr_regs
    import dxsmr_pkg::*;
#(
    parameter int          RESET_CYCLES     = `DXSMR_RESET_CYC,
    parameter int          RESET_WORK       = 16,
    parameter bit          PATTERN_TEST_OPT = 1'b1,
    parameter logic [21:0] OUI_BITS         = 22'h000000, // arbitrary value
    parameter logic [5:0]  MODEL_NUM        = 6'h00,      // arbitrary value
    parameter logic [3:0]  REVISION_NUM     = 4'h0,       // arbitrary value
    parameter int          DW               = 32
) (
    // clock and reset
    input  wire logic            clock_i,
    input  wire logic            nrst_i,
    // management access
    input  wire dxsmr_mgmt_req_t mgmt_req_i,
    output var  dxsmr_mgmt_rsp_t mgmt_rsp_o,
    // raw conditions from the datapath, same clock
    input  wire logic            link_up_i,
    input  wire logic            tx_fault_i,
    input  wire logic            rx_fault_i,
    input  wire logic [3:0]      lane_sync_i,
    input  wire logic            lane_align_i,
    // datapath
    input  wire logic [DW-1:0]   tx_data_i,
    input  wire logic [DW-1:0]   rx_line_i,
    output logic      [DW-1:0]   rx_data_o,
    // mode outputs
    output logic                 loopback_o,
    output logic                 low_power_o,
    output logic                 soft_reset_o,
    output var  dxsmr_test_t     test_o
);

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    function automatic logic is_addr(input dxsmr_mgmt_req_t r, input logic [15:0] a);
        is_addr = r.req && (r.addr == a);
    endfunction

    // ****************************************
    // software reset sequencer
    // ****************************************
    dxsmr_state_t state;
    logic [31:0]  rst_cnt;
    logic         wr_ctrl;
    logic         resetting;
    logic         clr_regs;

    // only control and test take writes
    assign wr_ctrl   = is_addr(mgmt_req_i, `DXSMR_A_CTRL1) && mgmt_req_i.wr;
    assign resetting = (state == DXSMR_RESETTING);
    // registers take defaults in the first reset cycle
    assign clr_regs  = resetting && (rst_cnt == 32'h0);

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state   <= DXSMR_RUN;
            rst_cnt <= 32'h0;
        end else begin
            case (state)
                DXSMR_RUN: begin
                    if (wr_ctrl && mgmt_req_i.wdata[`DXSMR_B_RESET]) begin
                        state   <= DXSMR_RESETTING;
                        rst_cnt <= 32'h0;
                    end
                end
                DXSMR_RESETTING: begin
                    if (rst_cnt >= 32'(RESET_WORK - 1)) begin
                        state <= DXSMR_RUN;
                    end else begin
                        rst_cnt <= rst_cnt + 32'h1;
                    end
                end
                default: state <= DXSMR_RUN;
            endcase
        end
    end

    // ****************************************
    // control register
    // ****************************************
    logic loop_en;
    logic lowpwr;

    // control bits; speed field is fixed so bad values never land
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            loop_en <= 1'b0;
            lowpwr  <= 1'b0;
        end else if (clr_regs) begin
            loop_en <= 1'b0;
            lowpwr  <= 1'b0;
        end else if (wr_ctrl && !resetting) begin
            loop_en <= mgmt_req_i.wdata[`DXSMR_B_LOOP];
            lowpwr  <= mgmt_req_i.wdata[`DXSMR_B_LOWPWR];
        end
    end

    // ****************************************
    // latching status
    // ****************************************
    logic rd_stat1;
    logic rd_stat2;
    logic link_lat;
    logic txf_lat;
    logic rxf_lat;

    assign rd_stat1 = is_addr(mgmt_req_i, `DXSMR_A_STAT1) && !mgmt_req_i.wr && !resetting;
    assign rd_stat2 = is_addr(mgmt_req_i, `DXSMR_A_STAT2) && !mgmt_req_i.wr && !resetting;

    // link latches low; a drop during the read cycle still wins
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            link_lat <= 1'b0;
        end else if (clr_regs) begin
            link_lat <= 1'b0;
        end else if (!link_up_i) begin
            link_lat <= 1'b0;
        end else if (rd_stat1) begin
            link_lat <= 1'b1;
        end
    end

    // faults latch high; a new fault outranks the read
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            txf_lat <= 1'b0;
            rxf_lat <= 1'b0;
        end else if (clr_regs) begin
            txf_lat <= 1'b0;
            rxf_lat <= 1'b0;
        end else begin
            txf_lat <= tx_fault_i || (txf_lat && !rd_stat2);
            rxf_lat <= rx_fault_i || (rxf_lat && !rd_stat2);
        end
    end

    // ****************************************
    // test pattern control
    // ****************************************
    logic       tst_en;
    logic [1:0] tst_sel;
    logic       wr_test;

    assign wr_test = is_addr(mgmt_req_i, `DXSMR_A_TEST) && mgmt_req_i.wr && !resetting;

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            {tst_en, tst_sel} <= `DXSMR_TEST_RST;
        end else if (clr_regs) begin
            {tst_en, tst_sel} <= `DXSMR_TEST_RST;
        end else if (wr_test && PATTERN_TEST_OPT) begin
            tst_en  <= mgmt_req_i.wdata[2];
            tst_sel <= mgmt_req_i.wdata[1:0];
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    logic [15:0] next_rdata;

    // every address answers, reserved reads zero
    always_comb begin
        next_rdata = 16'h0000;
        case (mgmt_req_i.addr)
            `DXSMR_A_CTRL1: begin
                next_rdata = `DXSMR_CTRL_RST;
                next_rdata[`DXSMR_B_RESET]  = resetting;
                next_rdata[`DXSMR_B_LOOP]   = loop_en && !resetting;
                next_rdata[`DXSMR_B_LOWPWR] = lowpwr && !resetting;
            end
            `DXSMR_A_STAT1: next_rdata = {13'h0, link_up_i && link_lat, lowpwr, 1'b0};
            `DXSMR_A_ID1,
            `DXSMR_A_PKG1:  next_rdata = OUI_BITS[21:6];
            `DXSMR_A_ID2,
            `DXSMR_A_PKG2:  next_rdata = {OUI_BITS[5:0], MODEL_NUM, REVISION_NUM};
            `DXSMR_A_SPEED: next_rdata = 16'h0001;
            `DXSMR_A_DEVS1: next_rdata = 16'h0020;
            `DXSMR_A_STAT2: next_rdata = {`DXSMR_PRESENT, 2'h0, txf_lat, rxf_lat, 10'h0};
            `DXSMR_A_LANE:  next_rdata = {3'h0, lane_align_i, 8'h0, lane_sync_i};
            `DXSMR_A_TEST:  next_rdata = PATTERN_TEST_OPT ? {13'h0, tst_en, tst_sel} : 16'h0000;
            default:        next_rdata = 16'h0000;
        endcase
        // only reset bit, fixed speed bits and present field while resetting
        if (resetting && mgmt_req_i.addr != `DXSMR_A_STAT2 && mgmt_req_i.addr != `DXSMR_A_CTRL1) begin
            next_rdata = 16'h0000;
        end
        if (resetting && mgmt_req_i.addr == `DXSMR_A_STAT2) begin
            next_rdata = {`DXSMR_PRESENT, 14'h0};
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rsp_o <= '0;
        end else begin
            mgmt_rsp_o.ack   <= mgmt_req_i.req;
            mgmt_rsp_o.rdata <= mgmt_req_i.req ? next_rdata : 16'h0000;
        end
    end

    // ****************************************
    // datapath and mode outputs
    // ****************************************
    // loopback returns transmit data
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_o <= '0;
        end else begin
            rx_data_o <= loop_en ? tx_data_i : rx_line_i;
        end
    end

    // mode pins follow the control bits
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            loopback_o   <= 1'b0;
            low_power_o  <= 1'b0;
            soft_reset_o <= 1'b0;
            test_o       <= '0;
        end else begin
            loopback_o   <= loop_en;
            low_power_o  <= lowpwr;
            soft_reset_o <= resetting;
            test_o       <= '{en: tst_en, sel: tst_sel};
        end
    end

    // ****************************************
    // checks
    // ****************************************
    int unsigned rst_age;
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            rst_age <= 0;
        end else begin
            rst_age <= resetting ? rst_age + 1 : 0;
        end
    end

    property p_reset_bound;
        @(posedge clock_i) disable iff (!rst_n) rst_age <= RESET_CYCLES;
    endproperty
    a_reset_bound: assert property (p_reset_bound) else $error("soft reset too long");

    property p_reset_reads_one;
        @(posedge clock_i) disable iff (!rst_n)
            resetting && is_addr(mgmt_req_i, `DXSMR_A_CTRL1) |=> mgmt_rsp_o.ack && mgmt_rsp_o.rdata[15];
    endproperty
    a_reset_reads_one: assert property (p_reset_reads_one) else $error("reset bit not one");

    property p_present_in_reset;
        @(posedge clock_i) disable iff (!rst_n)
            resetting && is_addr(mgmt_req_i, `DXSMR_A_STAT2) |=> mgmt_rsp_o.rdata[15:14] == `DXSMR_PRESENT;
    endproperty
    a_present_in_reset: assert property (p_present_in_reset) else $error("present field lost");

    property p_ack;
        @(posedge clock_i) disable iff (!rst_n) mgmt_req_i.req |=> mgmt_rsp_o.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("access not answered");

    property p_link_low_hold;
        @(posedge clock_i) disable iff (!rst_n) !link_up_i ##1 !rd_stat1 |=> !link_lat;
    endproperty
    a_link_low_hold: assert property (p_link_low_hold) else $error("link latch released early");

    property p_txf_hold;
        @(posedge clock_i) disable iff (!rst_n || clr_regs) txf_lat && !rd_stat2 |=> txf_lat;
    endproperty
    a_txf_hold: assert property (p_txf_hold) else $error("tx fault latch lost");

    property p_rxf_hold;
        @(posedge clock_i) disable iff (!rst_n || clr_regs) rxf_lat && !rd_stat2 && !clr_regs |=> rxf_lat;
    endproperty
    a_rxf_hold: assert property (p_rxf_hold) else $error("rx fault latch lost");

    property p_loop_data;
        @(posedge clock_i) disable iff (!rst_n) loop_en |=> rx_data_o == $past(tx_data_i);
    endproperty
    a_loop_data: assert property (p_loop_data) else $error("loopback data wrong");

    property p_ro_write;
        @(posedge clock_i) disable iff (!rst_n)
            mgmt_req_i.req && mgmt_req_i.wr && mgmt_req_i.addr != `DXSMR_A_CTRL1
            && mgmt_req_i.addr != `DXSMR_A_TEST && !clr_regs
            |=> $stable(loop_en) && $stable(lowpwr) && $stable(tst_en) && $stable(tst_sel);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write changed state");

    property p_test_zero;
        @(posedge clock_i) disable iff (!rst_n) !PATTERN_TEST_OPT |-> !tst_en;
    endproperty
    a_test_zero: assert property (p_test_zero) else $error("test enable set");

    c_soft_reset: cover property (@(posedge clock_i) disable iff (!rst_n) $fell(resetting));
    c_loopback:   cover property (@(posedge clock_i) disable iff (!rst_n) $rose(loop_en));
    c_link_read:  cover property (@(posedge clock_i) disable iff (!rst_n) !link_lat ##1 rd_stat1 ##1 link_lat);

endmodule
`default_nettype wire

// ===== verification/dxsmr_regs_tb.sv
// self-checking bench for the management register bank
`timescale 1ns/100ps
`default_nettype none

module dxsmr_regs_tb
    import dxsmr_pkg::*;
;
    localparam logic [21:0] OUI_BITS    = 22'h1A5C3E; // arbitrary value
    localparam logic [5:0] MODEL_NUM    = 6'h2B; // arbitrary value
    localparam logic [3:0] REVISION_NUM = 4'h9;  // arbitrary value

    logic            clock_i;
    logic            nrst_i;
    logic            link_up_i;
    logic            tx_fault_i;
    logic            rx_fault_i;
    logic            lane_align_i;
    logic [3:0]      lane_sync_i;
    logic [31:0]     tx_data_i;
    logic [31:0]     rx_line_i;
    logic [31:0]     rx_data_o;
    logic            loopback_o;
    logic            low_power_o;
    logic            soft_reset_o;
    dxsmr_test_t     test_o;
    dxsmr_mgmt_req_t mgmt_req;
    dxsmr_mgmt_rsp_t mgmt_rsp;
    dxsmr_mgmt_rsp_t np_rsp;
    dxsmr_test_t     np_test;
    logic            ack;
    logic [15:0]     rd;
    logic [15:0]     id1;
    logic [15:0]     lfsr;
    int              mismatches;
    int              samples_checked;
    int              m_loop, m_lp, m_ten, m_tsel, m_link, m_txf, m_rxf;
    logic [15:0]     addr_list [9] = '{16'h0000, 16'h0001, 16'h0004, 16'h0005, 16'h0008,
                                       16'h0018, 16'h0019, 16'h0007, 16'h001A};
    dxsmr_pattern_t  pats [3] = '{DXSMR_PAT_HIGH, DXSMR_PAT_LOW, DXSMR_PAT_MIXED};

    dxsmr_regs #(.RESET_CYCLES(64), .OUI_BITS(OUI_BITS), .MODEL_NUM(MODEL_NUM),
                 .REVISION_NUM(REVISION_NUM)) dut (
        .clock_i(clock_i), .nrst_i(nrst_i), .mgmt_req_i(mgmt_req), .mgmt_rsp_o(mgmt_rsp),
        .link_up_i(link_up_i), .tx_fault_i(tx_fault_i), .rx_fault_i(rx_fault_i),
        .lane_sync_i(lane_sync_i), .lane_align_i(lane_align_i), .tx_data_i(tx_data_i),
        .rx_line_i(rx_line_i), .rx_data_o(rx_data_o), .loopback_o(loopback_o),
        .low_power_o(low_power_o), .soft_reset_o(soft_reset_o), .test_o(test_o));

    dxsmr_sme sme (.clock_i(clock_i), .mgmt_req_o(mgmt_req), .mgmt_rsp_i(mgmt_rsp));

    // same bank built without pattern testing, fed the same accesses
    dxsmr_regs #(.RESET_CYCLES(64), .PATTERN_TEST_OPT(1'b0)) dut_nopat (
        .clock_i(clock_i), .nrst_i(nrst_i), .mgmt_req_i(mgmt_req), .mgmt_rsp_o(np_rsp),
        .link_up_i(link_up_i), .tx_fault_i(tx_fault_i), .rx_fault_i(rx_fault_i),
        .lane_sync_i(lane_sync_i), .lane_align_i(lane_align_i), .tx_data_i(tx_data_i),
        .rx_line_i(rx_line_i), .rx_data_o(), .loopback_o(), .low_power_o(),
        .soft_reset_o(), .test_o(np_test));

    // ****************************************
    // model and helpers
    // ****************************************
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    function automatic logic [15:0] model(input logic [15:0] a);
        case (a)
            16'h0000: return 16'h2040 | 16'(m_loop << 14 | m_lp << 11);
            16'h0001: return 16'((m_link & int'(link_up_i)) << 2 | m_lp << 1);
            16'h0004: return 16'h0001;
            16'h0005: return 16'h0020;
            16'h0008: return 16'h8000 | 16'(m_txf << 11 | m_rxf << 10);
            16'h0018: return {3'h0, lane_align_i, 8'h00, lane_sync_i};
            16'h0019: return 16'(m_ten << 2 | m_tsel);
            default:  return 16'h0000;
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [15:0] a);
        sme.access(1'b0, a, 16'h0000, ack, rd);
        check(ack, 1'b1);
        check(rd, model(a));
        if (a == 16'h0001) m_link = int'(link_up_i);
        if (a == 16'h0008) m_txf = int'(tx_fault_i);
        if (a == 16'h0008) m_rxf = int'(rx_fault_i);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        sme.access(1'b1, a, d, ack, rd);
        check(ack, 1'b1);
    endtask

    task automatic complete_run;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // clock, watchdog, sequence
    // ****************************************
    initial begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #(40 * 6000);
        mismatches++;
        complete_run();
    end

    initial begin
        nrst_i = 1'b0;
        link_up_i = 1'b1;
        tx_fault_i = 1'b0;
        rx_fault_i = 1'b0;
        lane_align_i = 1'b0;
        lane_sync_i = 4'h0;
        tx_data_i = 32'h0;
        rx_line_i = 32'h0;
        lfsr = 16'h0017;
        {m_loop, m_lp, m_ten, m_tsel, m_txf, m_rxf} = '0;
        m_link = 0;
        repeat (16) @(negedge clock_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge clock_i);
        // latched link status starts low, so the first read shows zero
        rd_chk(16'h0001);
        rd_chk(16'h0008);
        foreach (addr_list[i]) rd_chk(addr_list[i]);
        sme.access(1'b0, 16'h0002, 16'h0000, ack, id1);
        check(id1, OUI_BITS[21:6]);
        sme.access(1'b0, 16'h000E, 16'h0000, ack, rd);
        check(rd, id1);
        sme.access(1'b0, 16'h0003, 16'h0000, ack, rd);
        check(rd, {OUI_BITS[5:0], MODEL_NUM, REVISION_NUM});
        sme.access(1'b0, 16'h000F, 16'h0000, ack, rd);
        check(rd, {OUI_BITS[5:0], MODEL_NUM, REVISION_NUM});
        // random writes to read-only and undefined places
        lane_sync_i = lfsr[3:0];
        lane_align_i = lfsr[4];
        for (int i = 1; i < 9; i++) begin
            lfsr = step(lfsr);
            if (i != 6) wr(addr_list[i], lfsr);
        end
        foreach (addr_list[i]) rd_chk(addr_list[i]);
        // invalid speed field and reserved bits set alongside loopback and low power
        wr(16'h0000, 16'h4FBC);
        m_loop = 1;
        m_lp = 1;
        rd_chk(16'h0000);
        check(loopback_o, 1'b1);
        check(low_power_o, 1'b1);
        for (int n = 0; n < 6; n++) begin
            @(negedge clock_i);
            tx_data_i = {lfsr, ~lfsr};
            rx_line_i = {~lfsr, lfsr};
            lfsr = step(lfsr);
            @(negedge clock_i);
            check(rx_data_o, n < 3 ? tx_data_i : rx_line_i);
            if (n == 2) begin
                wr(16'h0000, 16'h0000);
                m_loop = 0;
                m_lp = 0;
                // mode pins trail the control bits by one cycle
                @(negedge clock_i);
                check(loopback_o, 1'b0);
                check(low_power_o, 1'b0);
            end
        end
        // one-cycle events must stay visible until read
        @(negedge clock_i);
        link_up_i = 1'b0;
        tx_fault_i = 1'b1;
        rx_fault_i = 1'b1;
        @(negedge clock_i);
        {link_up_i, tx_fault_i, rx_fault_i} = 3'b100;
        m_link = 0;
        m_txf = 1;
        m_rxf = 1;
        repeat (3) @(negedge clock_i);
        repeat (2) rd_chk(16'h0001);
        repeat (2) rd_chk(16'h0008);
        // pattern select with reserved bits set at random
        for (int s = 2; s >= 0; s--) begin
            lfsr = step(lfsr);
            wr(16'h0019, (lfsr & 16'hFFF8) | 16'h0004 | 16'(s));
            m_ten = 1;
            m_tsel = s;
            @(negedge clock_i);
            check(test_o.sel, pats[s]);
            check(test_o.en, 1'b1);
            check(np_test, 3'h0);
            rd_chk(16'h0019);
            check(np_rsp.rdata, 16'h0000);
        end
        // software reset from a non-default state
        wr(16'h0000, 16'h4000);
        wr(16'h0000, 16'hC000);
        @(negedge clock_i);
        check(soft_reset_o, 1'b1);
        sme.access(1'b0, 16'h0000, 16'h0000, ack, rd);
        check({ack, rd}, {1'b1, 16'hA040});
        sme.access(1'b0, 16'h0008, 16'h0000, ack, rd);
        check({ack, rd[15:14]}, 3'b110);
        sme.access(1'b0, 16'h0019, 16'h0000, ack, rd);
        check(rd, 16'h0000);
        for (int n = 0; n < 40 && soft_reset_o === 1'b1; n++) @(negedge clock_i);
        check(soft_reset_o, 1'b0);
        {m_loop, m_ten, m_tsel, m_link} = '0;
        rd_chk(16'h0000);
        rd_chk(16'h0001);
        rd_chk(16'h0019);
        check({loopback_o, test_o}, 4'h0);
        complete_run();
    end
endmodule

`default_nettype wire

// ===== verification/dxsmr_sme.sv
// station management model issuing register accesses
`timescale 1ns/100ps
`default_nettype none

module dxsmr_sme
    import dxsmr_pkg::*;
(
    // clock
    input  wire logic            clock_i,
    // management access
    output var  dxsmr_mgmt_req_t mgmt_req_o,
    input  wire dxsmr_mgmt_rsp_t mgmt_rsp_i
);
    initial mgmt_req_o = '0;

    // one access: request for one cycle, answer taken while it stands
    task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                          output logic ack, output logic [15:0] rdata);
        @(negedge clock_i);
        mgmt_req_o.req  = 1'b1;
        mgmt_req_o.wr   = wr;
        mgmt_req_o.addr = a;
        mgmt_req_o.wdata = (a == 16'h0000) ? (d | 16'h2040) : d;
        @(negedge clock_i);
        ack   = mgmt_rsp_i.ack;
        rdata = mgmt_rsp_i.rdata;
        mgmt_req_o.req = 1'b0;
        // released fields must not look like a held request
        mgmt_req_o.addr  = ~mgmt_req_o.addr;
        mgmt_req_o.wdata = ~mgmt_req_o.wdata;
    endtask
endmodule

`default_nettype wire
